// >>> ctw_defines.svh
// Register offsets, field positions, reset values and timing counts of the cascaded timer.
`ifndef CTW_DEFINES_SVH
`define CTW_DEFINES_SVH

`define CTW_OFS_CONFIG 8'h00
`define CTW_OFS_MODE 8'h04
`define CTW_OFS_CTRL 8'h08
`define CTW_OFS_COUNT_LO 8'h0c
`define CTW_OFS_COUNT_HI 8'h10

`define CTW_CFG_WATCHDOG_EN 7
`define CTW_CFG_CASCADE_EN 6
`define CTW_MODE_SRC_LO 2
`define CTW_MODE_SRC_HI 6
`define CTW_CTRL_LOWER_RUN 0
`define CTW_CTRL_UPPER_RUN 1
`define CTW_CTRL_LOWER_FLAG 2
`define CTW_CTRL_UPPER_FLAG 3
`define CTW_CTRL_POWER_DOWN 4

`define CTW_CONFIG_RESET 8'h00
`define CTW_MODE_RESET 8'h00

`define CTW_PHASES_PER_MC 4'd12
`define CTW_LAST_PHASE 4'd11
`define CTW_INCREMENT_PHASE 4'd4
`define CTW_FLAG_SET_PHASE 4'd8
`define CTW_SAMPLE_PHASE 4'd9
`define CTW_WD_RESET_MC 3'd5

`endif

// >>> ctw_event_src.sv
// External event source on the counter input.
`timescale 1ns/100ps
module ctw_event_src (
   // Clock and event pin.
   input wire logic clk_sys,
   output logic event_pin = 1'b0
);
   // Each level lasts two machine cycles so no edge falls between samples.
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         event_pin <= 1'b1;
         repeat (24) @(posedge clk_sys);
         event_pin <= 1'b0;
         repeat (24) @(posedge clk_sys);
      end
   endtask : burst
endmodule : ctw_event_src

// >>> ctw_pkg.sv
// Types shared by the cascaded timer and watchdog block.
package ctw_pkg;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } ctw_avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } ctw_avs_rsp_t;

   typedef struct packed {
      logic [3:0] phase;
      logic [7:0] config_reg;
      logic [7:0] mode_reg;
      logic lower_run;
      logic upper_run;
      logic lower_flag;
      logic upper_flag;
      logic power_down;
      logic [15:0] cnt_lo;
      logic [15:0] cnt_hi;
      logic [1:0] pend_ovf;
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] prev_lvl;
      logic [1:0] ev_pend;
      logic wd_arm;
      logic wd_active;
      logic [2:0] wd_cnt;
      logic ack;
      logic [31:0] rdata;
   } ctw_state_t;

endpackage : ctw_pkg

// >>> ctw_timer.sv
// Cascaded 32-bit timer/event counter with watchdog reset, Avalon-MM register slave.
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "ctw_defines.svh"

module ctw_timer
   import ctw_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Register bus.
   input wire ctw_avs_req_t avs_req,
   output ctw_avs_rsp_t avs_rsp,
   // Event pins, bit 0 feeds timer 0, bit 1 feeds timer 1.
   input wire logic [1:0] event_input,
   // Processor reset request and overflow interrupt levels.
   output logic core_reset,
   output logic [1:0] timer_irq
);

   // The carry and overflow compares are written for 16-bit halves only.
   if (COUNT_WIDTH != 16) begin : g_bad_width
      $error("ctw_timer supports only 16-bit halves");
   end

   ctw_state_t q;
   ctw_state_t s;

   // Picks the count source: machine cycles or a detected event.
   function automatic logic src_ok(input logic sel, input logic ev, input logic osc);
      src_ok = sel ? ev : osc;
   endfunction : src_ok

   function automatic logic [31:0] read_word(input ctw_state_t st, input logic [7:0] adr);
      read_word = 32'h0000_0000;
      if (adr == `CTW_OFS_CONFIG) begin
         read_word = {24'h00_0000, st.config_reg};
      end else if (adr == `CTW_OFS_MODE) begin
         read_word = {24'h00_0000, st.mode_reg};
      end else if (adr == `CTW_OFS_CTRL) begin
         read_word = {27'h000_0000, st.power_down, st.upper_flag, st.lower_flag,
                      st.upper_run, st.lower_run};
      end else if (adr == `CTW_OFS_COUNT_LO) begin
         read_word = {16'h0000, st.cnt_lo};
      end else if (adr == `CTW_OFS_COUNT_HI) begin
         read_word = {16'h0000, st.cnt_hi};
      end
   endfunction : read_word

   logic osc_run;
   logic inc_tick;
   logic flag_tick;
   logic samp_tick;
   logic mc_end;
   logic cnt_tick;
   logic cascade;
   logic step_lo;
   logic step_hi;
   logic ovf_lo;
   logic ovf_hi;
   logic req;
   logic wr_now;
   logic [1:0] new_flags;
   logic [31:0] wd;

   always_comb begin
      s = q;
      osc_run = !q.power_down;
      inc_tick = osc_run && (q.phase == `CTW_INCREMENT_PHASE);
      flag_tick = osc_run && (q.phase == `CTW_FLAG_SET_PHASE);
      samp_tick = !osc_run || (q.phase == `CTW_SAMPLE_PHASE);
      mc_end = osc_run && (q.phase == `CTW_LAST_PHASE);
      // With the oscillator stopped, events count as they are seen.
      cnt_tick = osc_run ? inc_tick : 1'b1;
      cascade = q.config_reg[`CTW_CFG_CASCADE_EN];
      req = avs_req.read || avs_req.write;
      wr_now = avs_req.write && q.ack;
      wd = avs_req.writedata;
      new_flags = 2'b00;

      if (osc_run) begin
         s.phase = mc_end ? 4'h0 : q.phase + 4'h1;
      end

      // Pins pass two flip-flops before anything looks at them.
      s.sync1 = event_input;
      s.sync2 = q.sync1;

      if (cnt_tick) begin
         s.ev_pend = 2'b00;
      end
      if (samp_tick) begin
         s.prev_lvl = q.sync2;
         s.ev_pend = s.ev_pend | (q.prev_lvl & ~q.sync2);
      end

      // The low half runs on its own run bit or on the cascade enable alone.
      step_lo = cnt_tick && (cascade || q.lower_run)
         && src_ok(q.mode_reg[`CTW_MODE_SRC_LO], q.ev_pend[0], osc_run);
      if (cascade) begin
         step_hi = step_lo && (q.cnt_lo == 16'hffff);
      end else begin
         step_hi = cnt_tick && q.upper_run
            && src_ok(q.mode_reg[`CTW_MODE_SRC_HI], q.ev_pend[1], osc_run);
      end
      // A carry out of the low half is silent while cascaded.
      ovf_lo = step_lo && !cascade && (q.cnt_lo == 16'hffff);
      ovf_hi = step_hi && (q.cnt_hi == 16'hffff);
      if (step_lo) begin
         s.cnt_lo = q.cnt_lo + 16'h0001;
      end
      if (step_hi) begin
         s.cnt_hi = q.cnt_hi + 16'h0001;
      end
      s.pend_ovf = q.pend_ovf | {ovf_hi, ovf_lo};

      // Bus answer: request seen, then one wait-free cycle.
      s.ack = req && !q.ack;
      if (req && !q.ack) begin
         s.rdata = read_word(q, avs_req.address);
      end
      if (wr_now) begin
         if (avs_req.address == `CTW_OFS_CONFIG) begin
            s.config_reg = wd[7:0];
         end else if (avs_req.address == `CTW_OFS_MODE) begin
            s.mode_reg = wd[7:0];
         end else if (avs_req.address == `CTW_OFS_CTRL) begin
            s.lower_run = wd[`CTW_CTRL_LOWER_RUN];
            s.upper_run = wd[`CTW_CTRL_UPPER_RUN];
            s.power_down = wd[`CTW_CTRL_POWER_DOWN];
            // Flags clear by writing one, so a read-modify-write also clears any flag read as set.
            if (wd[`CTW_CTRL_LOWER_FLAG]) begin
               s.lower_flag = 1'b0;
            end
            if (wd[`CTW_CTRL_UPPER_FLAG]) begin
               s.upper_flag = 1'b0;
            end
         end else if (avs_req.address == `CTW_OFS_COUNT_LO) begin
            s.cnt_lo = wd[15:0];
         end else if (avs_req.address == `CTW_OFS_COUNT_HI) begin
            s.cnt_hi = wd[15:0];
         end
      end

      // Flags are raised after any clear in the same cycle, so no overflow is lost.
      if (flag_tick) begin
         new_flags = q.pend_ovf;
         s.pend_ovf = {ovf_hi, ovf_lo};
      end else if (!osc_run) begin
         new_flags = s.pend_ovf;
         s.pend_ovf = 2'b00;
      end
      if (new_flags[0]) begin
         s.lower_flag = 1'b1;
      end
      if (new_flags[1]) begin
         s.upper_flag = 1'b1;
         if (q.config_reg[`CTW_CFG_WATCHDOG_EN]) begin
            s.wd_arm = 1'b1;
         end
      end

      // Watchdog reset: begins at the next machine cycle boundary, or at once
      // when the oscillator is stopped, since no boundary would ever come.
      if ((mc_end || !osc_run) && (q.wd_arm || (s.wd_arm && !osc_run))) begin
         s = '0;
         s.phase = osc_run ? 4'h0 : q.phase;
         s.sync1 = event_input;
         s.sync2 = q.sync1;
         s.ack = req && !q.ack;
         s.rdata = q.rdata;
         s.wd_active = 1'b1;
         s.wd_cnt = `CTW_WD_RESET_MC;
      end else if (mc_end && q.wd_active) begin
         s.wd_cnt = q.wd_cnt - 3'd1;
         if (q.wd_cnt == 3'd1) begin
            s.wd_active = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end

   assign avs_rsp.readdata = q.rdata;
   assign avs_rsp.waitrequest = req && !q.ack;
   assign core_reset = q.wd_active;
   assign timer_irq = {q.upper_flag, q.lower_flag};

endmodule : ctw_timer

// >>> ctw_timer_sva.sv
// Port assertions for the cascaded timer and watchdog.
`timescale 1ns/100ps
module ctw_timer_sva
   import ctw_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Bus and outputs.
   input wire ctw_avs_req_t avs_req,
   input wire ctw_avs_rsp_t avs_rsp,
   input wire logic core_reset,
   input wire logic [1:0] timer_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [7:0] hi_q;
   logic [4:0] age_q;
   wire req = avs_req.read | avs_req.write;
   wire done = req & !avs_rsp.waitrequest;
   // Length of the core reset pulse, and cycles since the upper flag was last seen.
   always_ff @(posedge clk_sys) begin
      hi_q <= (core_reset && !reset) ? hi_q + 8'h01 : 8'h00;
      age_q <= reset ? 5'h1f : timer_irq[1] ? 5'h00 : age_q + {4'h0, age_q != 5'h1f};
   end
   property p_wfirst; req && !$past(req) |-> avs_rsp.waitrequest; endproperty
   a_wfirst: assert property (p_wfirst) else $error("no wait cycle");
   property p_wone; req && avs_rsp.waitrequest |=> !avs_rsp.waitrequest; endproperty
   a_wone: assert property (p_wone) else $error("wait too long");
   property p_idle; !req |-> !avs_rsp.waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("idle wait");
   property p_unmap; done && avs_req.read && avs_req.address == 8'h14 |-> !avs_rsp.readdata;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   property p_rlen; $fell(core_reset) |-> hi_q == 8'h3c; endproperty
   a_rlen: assert property (p_rlen) else $error("reset length");
   property p_cause; $rose(core_reset) |-> age_q <= 5'h0c; endproperty
   a_cause: assert property (p_cause) else $error("reset without flag");
   property p_clr; $rose(core_reset) |=> timer_irq == 2'h0; endproperty
   a_clr: assert property (p_clr) else $error("flags kept");
   property p_hold;
      timer_irq[1] && !(done && avs_req.write && avs_req.address == 8'h08
         && avs_req.writedata[3]) |=> timer_irq[1] || core_reset;
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   c_rst: cover property ($rose(core_reset));
   c_ovf: cover property ($rose(timer_irq[1]));
   c_rd: cover property (done && avs_req.read);
endmodule : ctw_timer_sva
bind ctw_timer ctw_timer_sva u_ctw_timer_sva (.clk_sys(clk_sys), .reset(reset),
   .avs_req(avs_req), .avs_rsp(avs_rsp), .core_reset(core_reset), .timer_irq(timer_irq));

// >>> ctw_timer_test.sv
// Self-checking bench for the cascaded timer and watchdog.
`timescale 1ns/100ps
module ctw_timer_test
   import ctw_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   ctw_avs_req_t avs_req = '0;
   ctw_avs_rsp_t avs_rsp;
   logic core_reset;
   logic [1:0] timer_irq;
   logic ev;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   always #5 clk_sys = ~clk_sys;
   ctw_event_src u_ctw_event_src (.clk_sys(clk_sys), .event_pin(ev));
   ctw_timer u_ctw_timer (.clk_sys(clk_sys), .reset(reset), .avs_req(avs_req),
      .avs_rsp(avs_rsp), .event_input({ev, ev}), .core_reset(core_reset),
      .timer_irq(timer_irq));
   task automatic conclude;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
      do @(posedge clk_sys); while (avs_rsp.waitrequest !== 1'b0);
      q = avs_rsp.readdata;
      avs_req <= '0;
      @(posedge clk_sys);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd
   // Two reads of the low half whose sampling edges lie 120 clocks apart.
   task automatic rate(input logic [31:0] e);
      logic [31:0] q0, q1;
      bus(1'b0, 8'h0c, 32'h0, q0);
      repeat (117) @(posedge clk_sys);
      bus(1'b0, 8'h0c, 32'h0, q1);
      chk(q1 - q0, e);
   endtask : rate
   task automatic t_regs;
      rd(8'h00, 32'h0);
      wr(8'h14, 32'hff);
      rd(8'h14, 32'h0);
   endtask : t_regs
   task automatic t_cascade;
      wr(8'h10, 32'h12);
      wr(8'h0c, 32'hfffe);
      wr(8'h00, 32'h40);
      repeat (36) @(posedge clk_sys);
      rd(8'h10, 32'h13);
      rd(8'h08, 32'h0);
      wr(8'h10, 32'hffff);
      wr(8'h0c, 32'hfffe);
      repeat (36) @(posedge clk_sys);
      rd(8'h08, 32'h8);
      chk({30'h0, timer_irq}, 32'h2);
      rd(8'h10, 32'h0);
      rate(32'ha);
      wr(8'h08, 32'h8);
      rd(8'h08, 32'h0);
   endtask : t_cascade
   task automatic t_stop;
      wr(8'h00, 32'h0);
      rate(32'h0);
      wr(8'h08, 32'h1);
      rate(32'ha);
      wr(8'h08, 32'h0);
   endtask : t_stop
   task automatic t_events;
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h4);
      wr(8'h00, 32'h40);
      u_ctw_event_src.burst(5);
      repeat (30) @(posedge clk_sys);
      rd(8'h0c, 32'h5);
   endtask : t_events
   task automatic t_powerdown;
      wr(8'h00, 32'h0);
      wr(8'h0c, 32'hfffe);
      wr(8'h08, 32'h11);
      u_ctw_event_src.burst(2);
      repeat (4) @(posedge clk_sys);
      rd(8'h08, 32'h15);
      chk({30'h0, timer_irq}, 32'h1);
      rd(8'h0c, 32'h0);
      wr(8'h08, 32'h4);
      rd(8'h08, 32'h0);
   endtask : t_powerdown
   task automatic t_watchdog;
      int n;
      n = 0;
      wr(8'h04, 32'h0);
      wr(8'h10, 32'hffff);
      wr(8'h0c, 32'hfffe);
      wr(8'h00, 32'hc0);
      while (core_reset !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      n = 0;
      while (core_reset === 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(n), 32'h3c);
      rd(8'h00, 32'h0);
      rd(8'h0c, 32'h0);
   endtask : t_watchdog
   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs();
      t_cascade();
      t_stop();
      t_events();
      t_powerdown();
      t_watchdog();
      conclude();
   end
endmodule : ctw_timer_test
